// ==== verilog/mtr_resolver.sv ====
// Purpose: Resolves the effective memory type of each translated access.
// Assumes: Range registers arrive as flat ports; register port is the
//          model register read and write path of the core.
// Notes:   Result and address are registered together one cycle later.
//
// Function
// - Capability register read-only; writes fault.
// - Bits 7:0 report variable pair count.
// - Bit 8 reports fixed ranges present.
// - Bit 10 reports write-combining support.
// - Identification bit 12 set when ranges exist.
// - Cache-disable and write-through clear use range type.
// - Page cache disable gives uncacheable, but combining in a write-combining range with write-through clear.
// - Write-through page turns writeback into writethrough.
// - Write-combining range combined with page bits.
// - Mixed ranges in large page may be undefined.
// - Fixed ranges win in first megabyte.
// - Identical overlapping types keep that type.
// - Any uncacheable overlap gives uncacheable.
// - Writethrough with writeback overlap gives writethrough.
// - Other overlap mixes are undefined.
// - Sixty-four bit register of eight slots.
// - Type encodings 00,01,04,05,06 and 07.
// - Weak uncacheable acts uncacheable unless write-combining range.
// - Reserved bit writes fault.
// - Unsupported type writes fault, register unchanged.
// - Write-combining: uncached, combining, speculative reads.
// - Write-protect: shared read allocate, no write allocate.
// - Slot index from attribute, disable, through bits.
// - Reset slots begin writeback, writethrough, weak uncacheable.
// - Range matches when masked base equals masked address.
// - Global enable clear disables ranges, default uncacheable.
`timescale 1ns/1ps
`default_nettype none
module mtr_resolver
  import mtr_pkg::*;
#(
  parameter int         N_VAR    = 8,
  parameter logic       FIX_IMPL = 1'b1,
  parameter logic       WC_IMPL  = 1'b1,
  parameter logic [7:0] WC_PCD_NOWT_TYPE = MT_WC
) (
  // Clock and reset.
  input  wire logic                  clk,
  input  wire logic                  rst,
  // Model register port.
  input  wire mtr_op_t               reg_op,
  input  wire mtr_reg_t              reg_sel,
  input  wire logic [63:0]           reg_wdata,
  output logic [63:0]                reg_rdata,
  output logic                       reg_ack,
  output logic                       general_protection_fault,
  // Identification result bit.
  output logic                       id_range_feature,
  // Access from the paging unit.
  input  wire logic                  acc_valid,
  input  wire logic [PA_W-1:0]       acc_addr,
  input  wire logic                  page_attr_bit,
  input  wire logic                  page_cache_disable,
  input  wire logic                  page_write_through,
  input  wire logic                  global_cache_disable,
  // Range registers.
  input  wire logic [7:0]            fixed_type,
  input  wire logic [N_VAR*RANGE_W-1:0] range_base,
  input  wire logic [N_VAR*RANGE_W-1:0] range_mask,
  input  wire logic [N_VAR*8-1:0]    range_type,
  input  wire logic [N_VAR-1:0]      range_valid,
  // Result to the cache controller.
  output logic                       out_valid,
  output logic [PA_W-1:0]            out_addr,
  output logic [7:0]                 out_type,
  output logic                       out_cacheable,
  output logic                       out_combine_ok,
  output logic                       out_spec_read_ok,
  output logic                       out_read_alloc_shared,
  output logic                       out_write_alloc,
  output logic                       out_write_hit_inval
);
  logic [63:0] attr;
  logic [7:0]  slot_type;
  logic        attr_fault;
  logic        var_hit;
  logic [7:0]  var_type;
  logic [63:0] cap;
  logic [63:0] def_q;
  logic [63:0] def_d;

  // Read-only capability word.
  always_comb begin
    cap = '0;
    cap[CAP_CNT_LSB +: CAP_CNT_W] = CAP_CNT_W'(N_VAR);
    cap[CAP_FIX_BIT] = FIX_IMPL;
    cap[CAP_WC_BIT]  = WC_IMPL;
  end

  mtr_attr_slots u_slots (
    .clk       (clk),
    .rst       (rst),
    .wr_en     (reg_op == MTR_OP_WR && reg_sel == MTR_REG_ATTR),
    .wr_data   (reg_wdata),
    .idx       ({page_attr_bit, page_cache_disable, page_write_through}),
    .attr      (attr),
    .slot_type (slot_type),
    .wr_fault  (attr_fault)
  );

  mtr_var_merge #(.N(N_VAR)) u_merge (
    .addr        (acc_addr),
    .range_base  (range_base),
    .range_mask  (range_mask),
    .range_type  (range_type),
    .range_valid (range_valid),
    .hit         (var_hit),
    .merged      (var_type)
  );

  // Default type register: type, fixed enable and global enable.
  always_comb begin
    def_d = def_q;
    if (reg_op == MTR_OP_WR && reg_sel == MTR_REG_DEF) begin
      def_d = reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      def_q <= '0;
    end else begin
      def_q <= def_d;
    end
  end

  // Range type from fixed, variable and default ranges.
  function automatic logic [7:0] range_lookup(input logic [63:0] def,
                                              input logic [PA_W-1:0] a,
                                              input logic hit,
                                              input logic [7:0] vt,
                                              input logic [7:0] ft);
    if (!def[DEF_E_BIT]) begin
      range_lookup = MT_UC;
    end else if (FIX_IMPL && def[DEF_FE_BIT] && a[PA_W-1:FIXED_TOP_BIT] == '0) begin
      range_lookup = ft;
    end else if (hit) begin
      range_lookup = vt;
    end else begin
      range_lookup = def[7:0];
    end
  endfunction

  // Combines the range type with the selected attribute slot.
  function automatic logic [7:0] combine(input logic [7:0] rt,
                                         input logic [7:0] pt);
    combine = MT_UC;
    if (rt == MT_UC || pt == MT_UC) begin
      combine = MT_UC;
    end else if (pt == MT_UC_WEAK) begin
      combine = (rt == MT_WC) ? MT_WC : MT_UC;
    end else if (rt == MT_WC) begin
      // A writeback, writethrough or combining page slot keeps combining; a write-protect slot gives uncacheable.
      combine = (pt == MT_WB || pt == MT_WT || pt == MT_WC) ? MT_WC : MT_UC;
    end else if (pt == MT_WC) begin
      combine = MT_WC;
    end else if (pt == MT_WB) begin
      combine = rt;
    end else if (pt == MT_WT) begin
      combine = (rt == MT_WB) ? MT_WT : rt;
    end else begin
      combine = (rt == MT_WB || rt == MT_WP) ? MT_WP : rt;
    end
  endfunction

  // Next values of the access result.
  logic             out_valid_d;
  logic [PA_W-1:0]  out_addr_d;
  logic [7:0]       out_type_d;
  logic             cach_d;
  logic             comb_d;
  logic             spec_d;
  logic             rshare_d;
  logic             walloc_d;
  logic             winv_d;
  always_comb begin
    logic [7:0] rt;
    rt = range_lookup(def_q, acc_addr, var_hit, var_type, fixed_type);
    out_valid_d = acc_valid;
    out_addr_d  = acc_addr;
    if (global_cache_disable) begin
      out_type_d = MT_UC;
    end else if (page_cache_disable && !page_write_through && !page_attr_bit &&
                 rt == MT_WC) begin
      out_type_d = WC_PCD_NOWT_TYPE; // Chosen type for this case.
    end else begin
      out_type_d = combine(rt, slot_type);
    end
    cach_d   = (out_type_d == MT_WT) || (out_type_d == MT_WP) || (out_type_d == MT_WB);
    comb_d   = (out_type_d == MT_WC);
    spec_d   = (out_type_d == MT_WC) || cach_d;
    rshare_d = (out_type_d == MT_WT) || (out_type_d == MT_WP);
    walloc_d = (out_type_d == MT_WB);
    winv_d   = (out_type_d == MT_WP);
  end

  // Next values of the register port.
  logic [63:0] rdata_d;
  logic        ack_d;
  logic        gp_d;
  always_comb begin
    rdata_d = '0;
    ack_d   = reg_op != MTR_OP_NONE;
    gp_d    = 1'b0;
    if (reg_op == MTR_OP_RD) begin
      unique case (reg_sel)
        MTR_REG_CAP:  rdata_d = cap;
        MTR_REG_ATTR: rdata_d = attr;
        MTR_REG_DEF:  rdata_d = def_q;
        default:      rdata_d = '0;
      endcase
    end else if (reg_op == MTR_OP_WR) begin
      gp_d = (reg_sel == MTR_REG_CAP) | attr_fault;
    end
  end

  // Registers every output.
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= '0;
      reg_ack   <= 1'b0;
      general_protection_fault <= 1'b0;
      id_range_feature <= 1'b0;
      out_valid <= 1'b0;
      out_addr  <= '0;
      out_type  <= MT_UC;
      out_cacheable <= 1'b0;
      out_combine_ok <= 1'b0;
      out_spec_read_ok <= 1'b0;
      out_read_alloc_shared <= 1'b0;
      out_write_alloc <= 1'b0;
      out_write_hit_inval <= 1'b0;
    end else begin
      reg_rdata <= rdata_d;
      reg_ack   <= ack_d;
      general_protection_fault <= gp_d;
      id_range_feature <= 1'b1;
      out_valid <= out_valid_d;
      out_addr  <= out_addr_d;
      out_type  <= out_type_d;
      out_cacheable <= cach_d;
      out_combine_ok <= comb_d;
      out_spec_read_ok <= spec_d;
      out_read_alloc_shared <= rshare_d;
      out_write_alloc <= walloc_d;
      out_write_hit_inval <= winv_d;
    end
  end
endmodule
`default_nettype wire

// ==== verilog/mtr_pkg.sv ====
// Purpose: Shared constants for the memory type resolver.
// Assumes: Eight-bit type encodings, 64-bit attribute and capability words.
// Notes:   Positions, encodings and reset values are named here only.
package mtr_pkg;
  // Memory type encodings.
  localparam logic [7:0] MT_UC      = 8'h00;
  localparam logic [7:0] MT_WC      = 8'h01;
  localparam logic [7:0] MT_WT      = 8'h04;
  localparam logic [7:0] MT_WP      = 8'h05;
  localparam logic [7:0] MT_WB      = 8'h06;
  localparam logic [7:0] MT_UC_WEAK = 8'h07;
  // Capability field positions.
  localparam int CAP_CNT_LSB = 0;
  localparam int CAP_CNT_W   = 8;
  localparam int CAP_FIX_BIT = 8;
  localparam int CAP_WC_BIT  = 10;
  // Feature bit in the identification result.
  localparam int ID_RANGE_BIT = 12;
  // Default type register fields.
  localparam int DEF_FE_BIT = 10;
  localparam int DEF_E_BIT  = 11;
  // Physical address layout.
  localparam int PA_W     = 52;
  localparam int PA_LSB   = 12;
  localparam int RANGE_W  = 40;
  localparam int MASK_V_BIT = 11;
  // First megabyte limit for fixed ranges, as address bits 51:20 all zero.
  localparam int FIXED_TOP_BIT = 20;
  // Attribute slot layout.
  localparam int SLOT_N = 8;
  localparam int SLOT_W = 8;
  localparam int SLOT_TYPE_W = 3;
  // Reset value of the attribute register, slot 0 in the low byte.
  localparam logic [63:0] ATTR_RESET = 64'h0007_0406_0007_0406;
  // Operation codes of the register port.
  typedef enum logic [1:0] {
    MTR_OP_NONE,
    MTR_OP_RD,
    MTR_OP_WR
  } mtr_op_t;
  // Register selects of the register port.
  typedef enum logic [1:0] {
    MTR_REG_CAP,
    MTR_REG_ATTR,
    MTR_REG_DEF
  } mtr_reg_t;
endpackage

// ==== verilog/mtr_var_merge.sv ====
// Purpose: Combines the types of all matching variable ranges.
// Assumes: Base and mask vectors are flat, range n in slice n.
// Notes:   Purely combinational; the top registers the result.
`timescale 1ns/1ps
`default_nettype none
module mtr_var_merge
  import mtr_pkg::*;
#(
  parameter int N = 8
) (
  // Target address.
  input  wire logic [PA_W-1:0]      addr,
  // Range pairs.
  input  wire logic [N*RANGE_W-1:0] range_base,
  input  wire logic [N*RANGE_W-1:0] range_mask,
  input  wire logic [N*8-1:0]       range_type,
  input  wire logic [N-1:0]         range_valid,
  // Result.
  output logic                      hit,
  output logic [7:0]                merged
);
  // Folds every matching range into one type by overlap precedence.
  always_comb begin
    logic       any_uc;
    logic       only_wtwb;
    logic       any_wt;
    logic       same;
    logic [7:0] first;
    logic [RANGE_W-1:0] m;
    logic [RANGE_W-1:0] b;
    logic [7:0] t;
    m         = '0;
    b         = '0;
    t         = MT_UC;
    any_uc    = 1'b0;
    only_wtwb = 1'b1;
    any_wt    = 1'b0;
    same      = 1'b1;
    first     = MT_UC;
    hit       = 1'b0;
    for (int i = 0; i < N; i++) begin
      m = range_mask[i*RANGE_W +: RANGE_W];
      b = range_base[i*RANGE_W +: RANGE_W];
      t = range_type[i*8 +: 8];
      if (range_valid[i] && ((m & b) == (m & addr[PA_W-1:PA_LSB]))) begin
        if (!hit) begin
          first = t;
        end
        if (hit && t != first) begin
          same = 1'b0;
        end
        hit = 1'b1;
        any_uc = any_uc | (t == MT_UC);
        any_wt = any_wt | (t == MT_WT);
        only_wtwb = only_wtwb & ((t == MT_WT) | (t == MT_WB));
      end
    end
    if (same) begin
      merged = first;
    end else if (any_uc) begin
      merged = MT_UC;
    end else if (any_wt && only_wtwb) begin
      merged = MT_WT;
    end else begin
      merged = MT_UC; // Undefined mix: choose the safe type.
    end
  end
endmodule
`default_nettype wire

// ==== verilog/mtr_attr_slots.sv ====
// Purpose: Holds the eight attribute slots and checks writes to them.
// Assumes: Write strobe and data come from the top's register port.
// Notes:   A refused write leaves every slot unchanged.
`timescale 1ns/1ps
`default_nettype none
module mtr_attr_slots
  import mtr_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst,
  // Write request.
  input  wire logic        wr_en,
  input  wire logic [63:0] wr_data,
  // Slot lookup.
  input  wire logic [2:0]  idx,
  // Results.
  output logic [63:0]      attr,
  output logic [7:0]       slot_type,
  output logic             wr_fault
);
  logic [63:0] attr_q;
  logic [63:0] attr_d;

  // Returns true for a type that a slot may hold.
  function automatic logic slot_ok(input logic [7:0] t);
    slot_ok = (t == MT_UC) || (t == MT_WC) || (t == MT_WT) || (t == MT_WP) ||
              (t == MT_WB) || (t == MT_UC_WEAK);
  endfunction

  // Checks each slot: upper bits are reserved, the type must be known.
  always_comb begin
    logic bad;
    bad = 1'b0;
    for (int i = 0; i < SLOT_N; i++) begin
      if (wr_data[i*SLOT_W+SLOT_TYPE_W +: SLOT_W-SLOT_TYPE_W] != '0) begin
        bad = 1'b1;
      end
      if (!slot_ok(wr_data[i*SLOT_W +: SLOT_W])) begin
        bad = 1'b1;
      end
    end
    wr_fault = wr_en & bad;
    attr_d   = (wr_en && !bad) ? wr_data : attr_q;
  end

  // Registers the slots with their reset defaults.
  always_ff @(posedge clk) begin
    if (rst) begin
      attr_q <= ATTR_RESET;
    end else begin
      attr_q <= attr_d;
    end
  end

  assign attr      = attr_q;
  assign slot_type = attr_q[idx*SLOT_W +: SLOT_W];
endmodule
`default_nettype wire

// ==== dv/mtr_resolver_asserts.sv ====
// Purpose: Port-level assertions for the memory type resolver.
// Assumes: One clock domain, synchronous active-high reset.
// Notes:   Bound into every resolver instance at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
module mtr_resolver_asserts
  import mtr_pkg::*;
#(
  parameter int   N_VAR    = 8,
  parameter logic FIX_IMPL = 1'b1,
  parameter logic WC_IMPL  = 1'b1
) (
  // Clock and reset.
  input wire logic            clk,
  input wire logic            rst,
  // Register port.
  input wire mtr_op_t         reg_op,
  input wire mtr_reg_t        reg_sel,
  input wire logic [63:0]     reg_wdata,
  input wire logic [63:0]     reg_rdata,
  input wire logic            reg_ack,
  input wire logic            general_protection_fault,
  input wire logic            id_range_feature,
  // Access path.
  input wire logic            acc_valid,
  input wire logic [PA_W-1:0] acc_addr,
  input wire logic            out_valid,
  input wire logic [PA_W-1:0] out_addr,
  input wire logic [7:0]      out_type,
  input wire logic            out_cacheable,
  input wire logic            out_combine_ok,
  input wire logic            out_spec_read_ok,
  input wire logic            out_read_alloc_shared,
  input wire logic            out_write_alloc,
  input wire logic            out_write_hit_inval
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);
  // Request shapes that the properties start from.
  sequence s_cap_rd; reg_op == MTR_OP_RD && reg_sel == MTR_REG_CAP; endsequence
  sequence s_cap_wr; reg_op == MTR_OP_WR && reg_sel == MTR_REG_CAP; endsequence
  sequence s_rsv_wr;
    reg_op == MTR_OP_WR && reg_sel == MTR_REG_ATTR && |(reg_wdata & 64'hF8F8_F8F8_F8F8_F8F8);
  endsequence
  property p_cap_wr; s_cap_wr |=> reg_ack && general_protection_fault; endproperty
  a_cap_wr: assert property (p_cap_wr) else $error("capability write accepted");
  property p_cap_cnt; s_cap_rd |=> reg_ack && reg_rdata[7:0] == 8'(N_VAR); endproperty
  a_cap_cnt: assert property (p_cap_cnt) else $error("pair count wrong");
  property p_cap_flags; s_cap_rd |=> reg_rdata[8] == FIX_IMPL && reg_rdata[10] == WC_IMPL; endproperty
  a_cap_flags: assert property (p_cap_flags) else $error("capability flags wrong");
  property p_id; !rst ##1 !rst |-> id_range_feature; endproperty
  a_id: assert property (p_id) else $error("range feature bit low");
  property p_rsv; s_rsv_wr |=> reg_ack && general_protection_fault; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit write accepted");
  property p_wc;
    out_valid && out_type == MT_WC |-> !out_cacheable && out_combine_ok && out_spec_read_ok;
  endproperty
  a_wc: assert property (p_wc) else $error("combining attributes wrong");
  property p_wp;
    out_valid && out_type == MT_WP |-> out_read_alloc_shared && !out_write_alloc
      && out_write_hit_inval;
  endproperty
  a_wp: assert property (p_wp) else $error("protect attributes wrong");
  property p_out; acc_valid |=> out_valid && out_addr == $past(acc_addr); endproperty
  a_out: assert property (p_out) else $error("result not paired with address");
endmodule
bind mtr_resolver mtr_resolver_asserts #(.N_VAR(N_VAR), .FIX_IMPL(FIX_IMPL), .WC_IMPL(WC_IMPL))
  u_mtr_resolver_asserts (.clk, .rst, .reg_op, .reg_sel, .reg_wdata, .reg_rdata, .reg_ack,
  .general_protection_fault, .id_range_feature, .acc_valid, .acc_addr, .out_valid, .out_addr,
  .out_type, .out_cacheable, .out_combine_ok, .out_spec_read_ok, .out_read_alloc_shared,
  .out_write_alloc, .out_write_hit_inval);
`default_nettype wire

// ==== dv/mtr_range_src.sv ====
// Purpose: Range register source standing beside the resolver.
// Assumes: Two variable pairs, both covering the first 32 Mbytes.
// Notes:   Types and valid bits come from the bench per access.
`timescale 1ns/1ps
`default_nettype none
module mtr_range_src
  import mtr_pkg::*;
(
  // Choices of the bench.
  input  wire logic [15:0] types,
  input  wire logic [1:0]  vld,
  // Pairs toward the resolver.
  output logic [79:0]      range_base,
  output logic [79:0]      range_mask,
  output logic [15:0]      range_type,
  output logic [1:0]       range_valid
);
  // Base zero and a 32 Mbyte mask, so the two pairs overlap fully.
  assign range_base  = '0;
  assign range_mask  = {2{40'hFF_FFFF_E000}};
  assign range_type  = types;
  assign range_valid = vld;
endmodule
`default_nettype wire

// ==== dv/memory_type_resolver_test.sv ====
// Purpose: Self-checking bench for the memory type resolver.
// Assumes: Two variable pairs; fixed ranges and combining present.
// Notes:   Drivers queue expected results; a monitor compares on arrival.
`timescale 1ns/1ps
`default_nettype none
module memory_type_resolver_test
  import mtr_pkg::*;
;
  localparam logic [63:0] ATTR_ALT = 64'h0701_0500_0007_0406;
  logic            clk, rst, acc_valid, page_attr_bit, page_cache_disable, page_write_through;
  logic            global_cache_disable, reg_ack, general_protection_fault, id_range_feature;
  logic            out_valid, out_cacheable, out_combine_ok, out_spec_read_ok;
  logic            out_read_alloc_shared, out_write_alloc, out_write_hit_inval;
  mtr_op_t         reg_op;
  mtr_reg_t        reg_sel;
  logic [63:0]     reg_wdata, reg_rdata;
  logic [PA_W-1:0] acc_addr, out_addr;
  logic [7:0]      fixed_type, out_type, t0, t1;
  logic [79:0]     range_base, range_mask;
  logic [15:0]     range_type, types;
  logic [1:0]      range_valid, vld;
  logic [3:0]      pb;
  logic [64:0]     aq[$], rq[$];
  logic [31:0]     seed;
  logic [7:0]      tt[5] = '{MT_UC, MT_WC, MT_WT, MT_WP, MT_WB};
  logic [63:0]     bad[4] = '{64'h08, 64'h02, 64'h03, 64'h0080_0000_0000_0000};
  int              err_count = 0, samples_checked = 0, cycles = 0, i;

  mtr_resolver #(.N_VAR(2)) u_mtr_resolver (
    .clk, .rst, .reg_op, .reg_sel, .reg_wdata, .reg_rdata, .reg_ack,
    .general_protection_fault, .id_range_feature, .acc_valid, .acc_addr, .page_attr_bit,
    .page_cache_disable, .page_write_through, .global_cache_disable, .fixed_type,
    .range_base, .range_mask, .range_type, .range_valid, .out_valid, .out_addr, .out_type,
    .out_cacheable, .out_combine_ok, .out_spec_read_ok, .out_read_alloc_shared,
    .out_write_alloc, .out_write_hit_inval
  );
  mtr_range_src u_mtr_range_src (.types, .vld, .range_base, .range_mask, .range_type,
    .range_valid);

  // Step of the pseudo-random source.
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Merges the two pair types, then applies the page bits {gcd, pat, pcd, pwt}.
  function automatic logic [7:0] eff(input logic [7:0] a, b, input logic v1,
                                     input logic [3:0] p);
    logic [7:0] m;
    if (!v1 || a == b) m = a;
    else if (a == MT_UC || b == MT_UC) m = MT_UC;
    else if ({a, b} == {MT_WT, MT_WB} || {a, b} == {MT_WB, MT_WT}) m = MT_WT;
    else m = MT_UC;
    if (p[3] || (p[1] && !(m == MT_WC && !p[0]))) return MT_UC;
    if (p[0] && m == MT_WB) return MT_WT;
    return m;
  endfunction
  // Compares one result with its note and counts both outcomes.
  task automatic chk(input logic [64:0] got, input logic [64:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rreq(input mtr_op_t op, input mtr_reg_t s, input logic [63:0] d,
                      input logic [64:0] e);
    @(negedge clk);
    acc_valid = 1'b0;
    reg_op = op;
    reg_sel = s;
    reg_wdata = d;
    rq.push_back(e);
  endtask
  task automatic acc(input logic [51:0] a, input logic [3:0] p, input logic [15:0] t,
                     input logic v1, input logic [7:0] e);
    @(negedge clk);
    reg_op = MTR_OP_NONE;
    acc_valid = 1'b1;
    acc_addr = a;
    {global_cache_disable, page_attr_bit, page_cache_disable, page_write_through} = p;
    types = t;
    vld = {v1, 1'b1};
    aq.push_back({5'h0, a, e});
  endtask
  task automatic final_report;
    if (err_count == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Cuts a hung run short.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      err_count++;
      final_report();
    end
  end
  // Takes the oldest note whenever a result appears.
  always @(negedge clk) begin
    if (!rst && out_valid) chk({5'h0, out_addr, out_type}, aq.pop_front());
    if (!rst && reg_ack) chk({general_protection_fault, reg_rdata}, rq.pop_front());
  end
  // Main sequence.
  initial begin
    rst = 1'b1;
    {acc_valid, global_cache_disable, page_attr_bit, page_cache_disable} = '0;
    page_write_through = 1'b0;
    {reg_wdata, acc_addr, types, vld} = '0;
    reg_op = MTR_OP_NONE;
    reg_sel = MTR_REG_CAP;
    fixed_type = MT_WP;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    rreq(MTR_OP_RD, MTR_REG_CAP, '0, 65'h502);
    rreq(MTR_OP_WR, MTR_REG_CAP, 64'hFF, {1'b1, 64'h0});
    rreq(MTR_OP_RD, MTR_REG_CAP, '0, 65'h502);
    chk({64'h0, id_range_feature}, 65'h1);
    acc(52'h100_0000, 4'h0, {MT_WB, MT_WB}, 1'b1, MT_UC);
    rreq(MTR_OP_RD, MTR_REG_ATTR, '0, {1'b0, ATTR_RESET});
    rreq(MTR_OP_WR, MTR_REG_DEF, 64'hC04, '0);
    rreq(MTR_OP_WR, MTR_REG_ATTR, ATTR_ALT, '0);
    rreq(MTR_OP_RD, MTR_REG_ATTR, '0, {1'b0, ATTR_ALT});
    for (i = 0; i < 4; i++) rreq(MTR_OP_WR, MTR_REG_ATTR, bad[i], {1'b1, 64'h0});
    rreq(MTR_OP_RD, MTR_REG_ATTR, '0, {1'b0, ATTR_ALT});
    acc(52'h100_0000, 4'h4, {MT_WB, MT_WB}, 1'b1, MT_UC);
    acc(52'h100_0000, 4'h0, {MT_WB, MT_WB}, 1'b1, MT_WB);
    acc(52'h8_0000, 4'h0, {MT_UC, MT_UC}, 1'b1, MT_WP);
    acc(52'h400_0000, 4'h0, {MT_WB, MT_WB}, 1'b1, MT_WT);
    rreq(MTR_OP_WR, MTR_REG_ATTR, ATTR_RESET, '0);
    seed = 32'h9893;
    for (i = 0; i < 80; i++) begin
      seed = lfsr(lfsr(seed));
      t0 = tt[seed[25:23] % 5];
      t1 = tt[seed[31:29] % 5];
      pb = {seed[27] & seed[28], 1'b0, seed[22:21]};
      acc({32'h1, seed[19:0]}, pb, {t1, t0}, seed[26], eff(t0, t1, seed[26], pb));
    end
    @(negedge clk);
    acc_valid = 1'b0;
    repeat (3) @(negedge clk);
    chk(65'(aq.size() + rq.size()), '0);
    final_report();
  end
endmodule
`default_nettype wire
